// [pcs_top.sv]
// Program counter sequencer with APB register access
//
// The APB register port and the register offsets were left to the implementer.
`timescale 1ns/100ps
`include "pcs_consts.svh"
module pcs_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [`PCS_PC_W-1:0] mem_addr,
  output logic [`PCS_IR_W-1:0] mem_data,
  output logic mem_write,
  output logic instr_step
);
  import pcs_pkg::*;
  localparam int STEP_CYC = `PCS_STEP_CYC;
  // Architectural registers
  logic [`PCS_PC_W-1:0] pc_r; // Program counter
  logic [`PCS_IR_W-1:0] ir_r; // Instruction register
  logic [`PCS_ADD_W-1:0] rpt_r; // Repeat index register
  logic [`PCS_ADD_W-1:0] idx_r; // Selected index register value
  logic load_mode_r; // Load mode select
  logic match_r; // Last compare was zero
  pcs_st_e st_r; // Return jump sequencer
  logic [`PCS_PC_W-1:0] rj_addr_r; // Return jump target
  logic [6:0] step_cnt_r; // Microsecond step divider
  logic step_en_r; // Decode refresh strobe
  pcs_dec_s dec_r; // Latched decode
  pcs_dec_s dec_w; // Combinational decode
  // Bus decode
  logic acc; // Access phase
  logic wr; // Write strobe
  logic [2:0] cmd; // Command written
  pcs_seq_e seq; // Sequence requested
  logic [`PCS_PC_W-1:0] target; // Jump target
  logic chk_ok; // Load check address agrees
  logic [`PCS_ADD_W-1:0] add_a; // Adder operand a
  logic [`PCS_ADD_W-1:0] add_b; // Adder operand b
  logic add_one; // Adder carry in
  logic [`PCS_ADD_W-1:0] add_sum; // Adder result
  logic map_hit; // Address decodes
  logic [31:0] prdata_nxt; // Read data next value

  assign acc = psel & penable;
  assign wr = acc & pwrite & clk_en;
  assign cmd = pwdata[2:0];
  assign seq = pcs_seq_e'(pwdata[8:4]);
  assign target = pwdata[27:16];

  // Translator of the instruction register
  pcs_translator u_tr (
    .ir(ir_r),
    .step_en(step_en_r),
    .dec(dec_w)
  );

  // Refresh strobe every four microseconds
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_cnt_r <= 7'h00;
      step_en_r <= 1'b0;
    end else if (clk_en) begin
      if (step_cnt_r == 7'(STEP_CYC - 1)) begin
        step_cnt_r <= 7'h00;
        step_en_r <= 1'b1;
      end else begin
        step_cnt_r <= step_cnt_r + 7'h01;
        step_en_r <= 1'b0;
      end
    end
  end

  // Decode latch and step pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dec_r <= '0;
      instr_step <= 1'b0;
    end else if (clk_en) begin
      instr_step <= step_en_r;
      if (step_en_r) begin
        dec_r <= dec_w;
      end
    end
  end

  // Adder operand selection for lower instruction field
  always_comb begin
    add_a = ir_r[`PCS_ADD_W-1:0];
    add_b = 15'h0000;
    add_one = 1'b0;
    if (wr && paddr == `PCS_OFF_CMD) begin
      case (cmd)
        `PCS_CMD_CPL: begin
          add_b = 15'h7FFF;
        end
        `PCS_CMD_CMP: begin
          add_a = ~ir_r[`PCS_ADD_W-1:0];
          add_b = idx_r;
          add_one = 1'b1;
        end
        `PCS_CMD_LDW: begin
          add_one = load_mode_r;
        end
        `PCS_CMD_END: begin
          if (seq == PCS_SEQ_REPEAT) begin
            if (rpt_r[14:12] == 3'h1 || rpt_r[14:12] == 3'h3) begin
              add_one = 1'b1;
            end else if (rpt_r[12]) begin
              add_b = 15'h7FFF;
            end
          end
        end
        default: begin
          add_one = 1'b0;
        end
      endcase
    end
  end

  // 15-bit adder, top carry discarded
  assign add_sum = add_a + add_b + {14'h0000, add_one};

  // Complement without carries is a plain inversion
  logic cpl_sel; // Complement command active
  assign cpl_sel = wr && paddr == `PCS_OFF_CMD && cmd == `PCS_CMD_CPL;

  // Instruction register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ir_r <= 24'h000000;
      match_r <= 1'b0;
    end else if (clk_en) begin
      if (wr && paddr == `PCS_OFF_IR) begin
        ir_r <= pwdata[`PCS_IR_W-1:0];
      end else if (cpl_sel) begin
        ir_r[`PCS_ADD_W-1:0] <= ~ir_r[`PCS_ADD_W-1:0];
      end else if (wr && paddr == `PCS_OFF_CMD && cmd == `PCS_CMD_CMP) begin
        match_r <= (add_sum == 15'h0000);
      end else if (wr && paddr == `PCS_OFF_CMD) begin
        ir_r[`PCS_ADD_W-1:0] <= add_sum;
      end
    end
  end

  // Repeat index register and index operand
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rpt_r <= 15'h0000;
      idx_r <= 15'h0000;
    end else if (clk_en) begin
      if (wr && paddr == `PCS_OFF_RPT) begin
        rpt_r <= pwdata[`PCS_ADD_W-1:0];
      end else if (wr && paddr == `PCS_OFF_CMD && cmd == `PCS_CMD_END &&
                   seq == PCS_SEQ_REPEAT && rpt_r[11:0] != 12'h000) begin
        rpt_r[11:0] <= rpt_r[11:0] - 12'h001;
      end
      if (wr && paddr == `PCS_OFF_IDX) begin
        idx_r <= pwdata[`PCS_ADD_W-1:0];
      end
    end
  end

  // Load check address agrees with counter
  assign chk_ok = (target == pc_r);

  // Program counter and return jump sequence
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_r <= 12'h000;
      st_r <= PCS_ST_IDLE;
      rj_addr_r <= 12'h000;
    end else if (clk_en) begin
      case (st_r)
        PCS_ST_IDLE: begin
          if (wr && paddr == `PCS_OFF_CTRL && pwdata[1]) begin
            pc_r <= 12'h000;
          end else if (wr && paddr == `PCS_OFF_CMD) begin
            case (cmd)
              `PCS_CMD_PCSET: begin
                pc_r <= ir_r[`PCS_PC_W-1:0];
              end
              `PCS_CMD_LCHK: begin
                if (load_mode_r && chk_ok) begin
                  pc_r <= pc_r + 12'h001;
                end
              end
              `PCS_CMD_END: begin
                if (!load_mode_r) begin
                  case (seq)
                    PCS_SEQ_REPEAT: begin
                      if (rpt_r[11:0] == 12'h001 ||
                          rpt_r[11:0] == 12'h000) begin
                        pc_r <= pc_r + 12'h001;
                      end
                    end
                    PCS_SEQ_SKIP: begin
                      pc_r <= pc_r + 12'h002;
                    end
                    PCS_SEQ_JUMP: begin
                      pc_r <= target;
                    end
                    PCS_SEQ_RJUMP: begin
                      rj_addr_r <= target;
                      st_r <= PCS_ST_RJ_STORE;
                    end
                    default: begin
                      pc_r <= pc_r + 12'h001;
                    end
                  endcase
                end
              end
              default: begin
                pc_r <= pc_r;
              end
            endcase
          end
        end
        PCS_ST_RJ_STORE: begin
          st_r <= PCS_ST_RJ_LOAD;
        end
        PCS_ST_RJ_LOAD: begin
          pc_r <= rj_addr_r + 12'h001;
          st_r <= PCS_ST_IDLE;
        end
        default: begin
          st_r <= PCS_ST_IDLE;
        end
      endcase
    end
  end

  // Load mode control
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      load_mode_r <= 1'b0;
    end else if (clk_en && wr && paddr == `PCS_OFF_CTRL) begin
      load_mode_r <= pwdata[0];
    end
  end

  // Memory address and data registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_addr <= 12'h000;
      mem_data <= 24'h000000;
      mem_write <= 1'b0;
    end else if (clk_en) begin
      mem_write <= 1'b0;
      if (st_r == PCS_ST_RJ_STORE) begin
        mem_addr <= rj_addr_r;
        mem_data <= {12'h000, pc_r};
        mem_write <= 1'b1;
      end else if (wr && paddr == `PCS_OFF_CMD && cmd == `PCS_CMD_LDW &&
                   load_mode_r) begin
        mem_addr <= ir_r[`PCS_PC_W-1:0];
        mem_data <= pwdata[31:8];
        mem_write <= 1'b1;
      end else if (wr && paddr == `PCS_OFF_CMD && cmd == `PCS_CMD_FETCH &&
                   !load_mode_r) begin
        mem_addr <= pc_r;
      end
    end
  end

  // APB read mux and answer
  always_comb begin
    map_hit = 1'b1;
    case (paddr)
      `PCS_OFF_CTRL: prdata_nxt = {31'h00000000, load_mode_r};
      `PCS_OFF_CMD: prdata_nxt = 32'h00000000;
      `PCS_OFF_IR: prdata_nxt = {8'h00, ir_r};
      `PCS_OFF_PC: prdata_nxt = {20'h00000, pc_r};
      `PCS_OFF_RPT: prdata_nxt = {17'h00000, rpt_r};
      `PCS_OFF_IDX: prdata_nxt = {17'h00000, idx_r};
      `PCS_OFF_MAR: prdata_nxt = {20'h00000, mem_addr};
      `PCS_OFF_MDR: prdata_nxt = {8'h00, mem_data};
      `PCS_OFF_STAT: prdata_nxt = {26'h0000000, st_r, match_r, load_mode_r,
                                   ~st_r[0]};
      `PCS_OFF_DEC: prdata_nxt = {dec_r.idx_hot, dec_r.mod_hot, 15'h0000,
                                  dec_r.mod_used};
      default: begin
        prdata_nxt = 32'h00000000;
        map_hit = 1'b0;
      end
    endcase
  end

  // Registered answer in the cycle after setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~map_hit;
      if (psel && !penable && !pwrite) begin
        prdata <= prdata_nxt;
      end
    end
  end
endmodule

// [pcs_consts.svh]
// Constants for the program counter sequencer
`ifndef PCS_CONSTS_SVH
`define PCS_CONSTS_SVH
`define PCS_PC_W 12
`define PCS_IR_W 24
`define PCS_ADD_W 15
`define PCS_RPT_W 12
`define PCS_OP_LSB 18
`define PCS_OP_MSB 23
`define PCS_IDX_LSB 15
`define PCS_IDX_MSB 17
`define PCS_MOD_LSB 12
`define PCS_MOD_MSB 14
`define PCS_STEP_US 4
`define PCS_CLK_MHZ 25
`define PCS_STEP_CYC (`PCS_STEP_US * `PCS_CLK_MHZ)
`define PCS_OFF_CTRL 12'h000
`define PCS_OFF_CMD 12'h004
`define PCS_OFF_IR 12'h008
`define PCS_OFF_PC 12'h00C
`define PCS_OFF_RPT 12'h010
`define PCS_OFF_IDX 12'h014
`define PCS_OFF_MAR 12'h018
`define PCS_OFF_MDR 12'h01C
`define PCS_OFF_STAT 12'h020
`define PCS_OFF_DEC 12'h024
`define PCS_CMD_END 3'h1
`define PCS_CMD_CMP 3'h2
`define PCS_CMD_CPL 3'h3
`define PCS_CMD_LDW 3'h4
`define PCS_CMD_LCHK 3'h5
`define PCS_CMD_PCSET 3'h6
`define PCS_CMD_FETCH 3'h7
`endif

// [pcs_pkg.sv]
// Types shared by the program counter sequencer files
package pcs_pkg;
  typedef enum logic [4:0] {
    PCS_SEQ_NEXT = 5'h01,
    PCS_SEQ_REPEAT = 5'h02,
    PCS_SEQ_SKIP = 5'h04,
    PCS_SEQ_JUMP = 5'h08,
    PCS_SEQ_RJUMP = 5'h10
  } pcs_seq_e;
  typedef struct packed {
    logic [63:0] op_hot;
    logic [7:0] idx_hot;
    logic [7:0] mod_hot;
    logic mod_used;
  } pcs_dec_s;
  typedef enum logic [2:0] {
    PCS_ST_IDLE = 3'h1,
    PCS_ST_RJ_STORE = 3'h2,
    PCS_ST_RJ_LOAD = 3'h4
  } pcs_st_e;
endpackage

// [pcs_translator.sv]
// Opcode, index and modifier translators of the instruction register
`timescale 1ns/100ps
`include "pcs_consts.svh"
module pcs_translator (
  input wire logic [`PCS_IR_W-1:0] ir,
  input wire logic step_en,
  output pcs_pkg::pcs_dec_s dec
);
  import pcs_pkg::*;
  logic [5:0] opc; // Opcode field
  logic [2:0] idx; // Index select field
  logic [2:0] modf; // Modifier field
  assign opc = ir[`PCS_OP_MSB:`PCS_OP_LSB];
  assign idx = ir[`PCS_IDX_MSB:`PCS_IDX_LSB];
  assign modf = ir[`PCS_MOD_MSB:`PCS_MOD_LSB];
  // One AND term per opcode value
  genvar g;
  generate
    for (g = 0; g < 64; g++) begin : g_op
      assign dec.op_hot[g] = step_en & (opc == 6'(g));
    end
    for (g = 0; g < 8; g++) begin : g_sel
      assign dec.idx_hot[g] = (idx == 3'(g));
      assign dec.mod_hot[g] = dec.mod_used & (modf == 3'(g));
    end
  endgenerate
  // Modifier used by read, write, jump, input, output classes
  assign dec.mod_used = step_en & (opc[5:4] != 2'h3);
endmodule

// [pcs_props.sv]
// Checker for the sequencer bus answer and pulse outputs
`timescale 1ns/100ps
module pcs_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic mem_write,
  input wire logic instr_step
);
  // Cycles since the last step pulse
  logic [7:0] cnt_r;
  // High once a first step was seen
  logic seen_r;
  // Step spacing counter, frozen with the clock enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 8'h00;
      seen_r <= 1'b0;
    end else if (instr_step) begin
      cnt_r <= 8'h00;
      seen_r <= 1'b1;
    end else if (clk_en) begin
      cnt_r <= cnt_r + 8'h01;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_setup_gets_ready: assert property (psel && !penable && clk_en |=> pready)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("ready outside access phase");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_rdata_on_read: assert property ($changed(prdata) |-> pready && !pwrite)
    else $error("read data moved outside a read");
  a_store_pulse: assert property (mem_write |=> !mem_write)
    else $error("memory write longer than one cycle");
  a_step_gap: assert property (instr_step |=> !instr_step [*8])
    else $error("step pulses too close");
  a_step_period: assert property (instr_step && seen_r |-> cnt_r == 8'h63)
    else $error("step period wrong");
  a_step_not_late: assert property (seen_r |-> cnt_r <= 8'h63)
    else $error("step pulse overdue");
  c_store: cover property (mem_write);
  c_error: cover property (pslverr);
  c_step: cover property (instr_step && seen_r);
endmodule
bind pcs_top pcs_props pcs_props_inst (.pclk(pclk), .presetn(presetn),
  .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .mem_write(mem_write), .instr_step(instr_step));

// [pcs_mem_model.sv]
// Core memory model that captures stores from the sequencer
`timescale 1ns/100ps
`include "pcs_consts.svh"
module pcs_mem_model (
  input wire logic pclk,
  input wire logic [`PCS_PC_W-1:0] mem_addr,
  input wire logic [`PCS_IR_W-1:0] mem_data,
  input wire logic mem_write
);
  // Word store, unwritten words stay unknown
  logic [`PCS_IR_W-1:0] mem [0:4095];
  // Store on the write pulse at the given address
  always_ff @(posedge pclk) begin
    if (mem_write) begin
      mem[mem_addr] <= mem_data;
    end
  end
endmodule

// [tb_top.sv]
// Self-checking bench for the program counter sequencer
`timescale 1ns/100ps
`include "pcs_consts.svh"
module tb_top;
  import pcs_pkg::*;
  localparam logic [31:0] PCM = 32'h00000FFF;
  localparam logic [31:0] IRM = 32'h00FFFFFF;
  logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic mem_write, instr_step, err;
  logic [`PCS_PC_W-1:0] mem_addr;
  logic [`PCS_IR_W-1:0] mem_data;
  int n_fail;
  int samples_checked;
  int n_wait;
  pcs_top pcs_top_inst (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mem_addr(mem_addr), .mem_data(mem_data), .mem_write(mem_write),
    .instr_step(instr_step));
  pcs_mem_model pcs_mem_model_inst (.pclk(pclk), .mem_addr(mem_addr),
    .mem_data(mem_data), .mem_write(mem_write));
  // Compare and count
  task automatic chk(input string nm, input logic [31:0] exp, got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One APB transfer, held until ready is sampled
  task automatic bus(input logic wr, input logic [11:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    if (n >= 64) n_fail++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Read a register and compare the masked bits
  task automatic rchk(input string nm, input logic [11:0] a,
    input logic [31:0] m, exp);
    bus(1'b0, a, 32'h0);
    chk(nm, exp, rd & m);
  endtask
  // Issue a command and let its effects settle
  task automatic cmd(input logic [2:0] c, input logic [4:0] s,
    input logic [11:0] t);
    bus(1'b1, `PCS_OFF_CMD, {4'h0, t, 7'h00, s, 1'b0, c});
    repeat (2) @(posedge pclk);
  endtask
  // Print counts and verdict, then end
  task stop_test;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Clock at 25 MHz
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // Watchdog cuts a hang short
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    stop_test();
  end
  // Main sequence
  initial begin
    n_fail = 0;
    samples_checked = 0;
    presetn = 1'b0;
    clk_en = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rchk("pc", `PCS_OFF_PC, PCM, 32'h0);
    cmd(`PCS_CMD_END, PCS_SEQ_NEXT, 12'h0);
    rchk("pc", `PCS_OFF_PC, PCM, 32'h1);
    cmd(`PCS_CMD_END, PCS_SEQ_SKIP, 12'h0);
    rchk("pc", `PCS_OFF_PC, PCM, 32'h3);
    cmd(`PCS_CMD_END, PCS_SEQ_JUMP, 12'hFFF);
    rchk("pc", `PCS_OFF_PC, PCM, 32'hFFF);
    cmd(`PCS_CMD_END, PCS_SEQ_NEXT, 12'h0);
    rchk("pc", `PCS_OFF_PC, PCM, 32'h0);
    cmd(`PCS_CMD_END, PCS_SEQ_JUMP, 12'h020);
    cmd(`PCS_CMD_END, PCS_SEQ_RJUMP, 12'h100);
    chk("stored", 32'h20, {8'h0, pcs_mem_model_inst.mem[12'h100]});
    rchk("pc", `PCS_OFF_PC, PCM, 32'h101);
    cmd(`PCS_CMD_FETCH, 5'h0, 12'h0);
    chk("mem_addr", 32'h101, {20'h0, mem_addr});
    // Repeat three times, modifier 1 advances the address fields
    bus(1'b1, `PCS_OFF_RPT, 32'h00001003);
    bus(1'b1, `PCS_OFF_IR, 32'h00000040);
    cmd(`PCS_CMD_END, PCS_SEQ_REPEAT, 12'h0);
    rchk("pc", `PCS_OFF_PC, PCM, 32'h101);
    rchk("count", `PCS_OFF_RPT, PCM, 32'h2);
    cmd(`PCS_CMD_END, PCS_SEQ_REPEAT, 12'h0);
    cmd(`PCS_CMD_END, PCS_SEQ_REPEAT, 12'h0);
    rchk("pc", `PCS_OFF_PC, PCM, 32'h102);
    rchk("ir", `PCS_OFF_IR, IRM, 32'h43);
    bus(1'b1, `PCS_OFF_IR, 32'h00000ABC);
    cmd(`PCS_CMD_PCSET, 5'h0, 12'h0);
    rchk("pc", `PCS_OFF_PC, PCM, 32'hABC);
    bus(1'b1, `PCS_OFF_IR, 32'h0);
    cmd(`PCS_CMD_CPL, 5'h0, 12'h0);
    rchk("ir", `PCS_OFF_IR, IRM, 32'h7FFF);
    cmd(`PCS_CMD_CPL, 5'h0, 12'h0);
    rchk("ir", `PCS_OFF_IR, IRM, 32'h0);
    bus(1'b1, `PCS_OFF_IR, 32'h5);
    bus(1'b1, `PCS_OFF_IDX, 32'h7);
    cmd(`PCS_CMD_CMP, 5'h0, 12'h0);
    rchk("ir", `PCS_OFF_IR, IRM, 32'h5);
    rchk("match", `PCS_OFF_STAT, 32'h4, 32'h0);
    bus(1'b1, `PCS_OFF_IDX, 32'h5);
    cmd(`PCS_CMD_CMP, 5'h0, 12'h0);
    rchk("match", `PCS_OFF_STAT, 32'h4, 32'h4);
    // Load mode: two words stored back to back
    bus(1'b1, `PCS_OFF_CTRL, 32'h1);
    bus(1'b1, `PCS_OFF_IR, 32'h10);
    bus(1'b1, `PCS_OFF_CMD, {24'hABCDEF, 5'h0, `PCS_CMD_LDW});
    bus(1'b1, `PCS_OFF_CMD, {24'h123456, 5'h0, `PCS_CMD_LDW});
    repeat (2) @(posedge pclk);
    chk("word0", 32'hABCDEF, {8'h0, pcs_mem_model_inst.mem[12'h010]});
    chk("word1", 32'h123456, {8'h0, pcs_mem_model_inst.mem[12'h011]});
    rchk("ir", `PCS_OFF_IR, IRM, 32'h12);
    bus(1'b1, `PCS_OFF_CTRL, 32'h2);
    bus(1'b1, `PCS_OFF_CTRL, 32'h0);
    rchk("pc", `PCS_OFF_PC, PCM, 32'h0);
    // Load check counter: a matching check advances, a wrong one holds
    bus(1'b1, `PCS_OFF_CTRL, 32'h1);
    cmd(`PCS_CMD_LCHK, 5'h0, 12'h000);
    cmd(`PCS_CMD_LCHK, 5'h0, 12'h005);
    rchk("pc", `PCS_OFF_PC, PCM, 32'h1);
    bus(1'b1, `PCS_OFF_CTRL, 32'h0);
    // Step pulse must appear within 200 cycles, two refresh periods
    n_wait = 0;
    while (instr_step !== 1'b1 && n_wait < 200) begin
      @(posedge pclk);
      n_wait++;
    end
    chk("step", 32'h1, {31'h0, instr_step});
    bus(1'b0, 12'h030, 32'h0);
    chk("pslverr", 32'h1, {31'h0, err});
    stop_test();
  end
endmodule
